/* File: rtl/dupin_pins.sv */
// Pin stage of a two-channel UART: interrupt gating, ready flags, modem pins.
// Assumes the core runs on ref_clk_i and hands its state over as structs.
`timescale 1ns/1ps
`default_nettype none
`include "duart_pin_cfg.svh"

// Overview of operation
// - Split-strobe mode: channel B pin carries channel B interrupt.
// - Split-strobe, B out2 set: drive B interrupt, aux pin B low.
// - Split-strobe, B out2 clear: B interrupt floats, aux pin B high.
// - Single-strobe mode: B interrupt pin held at logic zero.
// - Split-strobe: channel A interrupt gated by its out2, aux A complement.
// - Single-strobe: A pin is combined open-drain active-low interrupt.
// - Per-channel active-low transmitter-ready output.
// - Per-channel active-low receiver-ready output.
// - Each channel drives its own serial transmit output.
// - Each channel drives active-low request-to-send, usable as general output.
// - Each channel drives active-low terminal-ready, usable as general output.
// - Clear-to-send sampled for handshaking or general input.
// - Set-ready, carrier and ring sampled as general inputs.
// - Set-ready, carrier and ring never affect UART operation.
module dupin_pins
  import dupin_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bus_mode_i,
  input wire dupin_core_s core_a_i,
  input wire dupin_core_s core_b_i,
  input wire dupin_modem_in_s modem_a_i,
  input wire dupin_modem_in_s modem_b_i,
  input wire logic chan_a_serial_in_i,
  input wire logic chan_b_serial_in_i,
  output logic chan_a_irq_out_o,
  output logic chan_a_irq_out_oe_n_o,
  output logic chan_b_irq_out_o,
  output logic chan_b_irq_out_oe_n_o,
  output logic chan_a_aux_out_n_o,
  output logic chan_b_aux_out_n_o,
  output logic chan_a_tx_ready_n_o,
  output logic chan_b_tx_ready_n_o,
  output logic chan_a_rx_ready_n_o,
  output logic chan_b_rx_ready_n_o,
  output logic chan_a_serial_out_o,
  output logic chan_b_serial_out_o,
  output logic chan_a_req_send_n_o,
  output logic chan_b_req_send_n_o,
  output logic chan_a_term_ready_n_o,
  output logic chan_b_term_ready_n_o,
  output logic [`DUPIN_NUM_CHAN-1:0] clear_send_n_o,
  output dupin_modem_in_s modem_a_sync_o,
  output dupin_modem_in_s modem_b_sync_o,
  output logic [`DUPIN_NUM_CHAN-1:0] serial_in_o
);

  dupin_core_s core [`DUPIN_NUM_CHAN];
  dupin_modem_in_s modem_raw [`DUPIN_NUM_CHAN];
  logic [`DUPIN_NUM_CHAN-1:0] ser_raw;
  logic [`DUPIN_NUM_CHAN-1:0] irq_ff, nxt_irq;
  logic [`DUPIN_NUM_CHAN-1:0] oe_n_ff, nxt_oe_n;
  logic [`DUPIN_NUM_CHAN-1:0] aux_n_ff, nxt_aux_n;
  logic [`DUPIN_NUM_CHAN-1:0] txr_n_ff, nxt_txr_n;
  logic [`DUPIN_NUM_CHAN-1:0] rxr_n_ff, nxt_rxr_n;
  logic [`DUPIN_NUM_CHAN-1:0] sout_ff, nxt_sout;
  logic [`DUPIN_NUM_CHAN-1:0] rts_n_ff, nxt_rts_n;
  logic [`DUPIN_NUM_CHAN-1:0] dtr_n_ff, nxt_dtr_n;
  dupin_modem_in_s meta_ff [`DUPIN_NUM_CHAN];
  dupin_modem_in_s sync_ff [`DUPIN_NUM_CHAN];
  logic [`DUPIN_NUM_CHAN-1:0] ser_meta_ff, ser_sync_ff;
  dupin_mode_e mode;
  logic any_irq;

  assign core[`DUPIN_CHAN_A] = core_a_i;
  assign core[`DUPIN_CHAN_B] = core_b_i;
  assign modem_raw[`DUPIN_CHAN_A] = modem_a_i;
  assign modem_raw[`DUPIN_CHAN_B] = modem_b_i;
  assign ser_raw = {chan_b_serial_in_i, chan_a_serial_in_i};
  assign mode = dupin_mode_e'(bus_mode_i);
  assign any_irq = core_a_i.irq | core_b_i.irq;

  always_comb begin
    nxt_irq = '0;
    nxt_oe_n = '1;
    nxt_aux_n = '1;
    for (int c = 0; c < `DUPIN_NUM_CHAN; c++) begin
      nxt_aux_n[c] = ~core[c].out2;
      nxt_txr_n[c] = ~core[c].tx_can_accept;
      nxt_rxr_n[c] = ~core[c].rx_has_data;
      nxt_sout[c] = core[c].serial_out;
      nxt_rts_n[c] = ~core[c].req_send;
      nxt_dtr_n[c] = ~core[c].term_ready;
    end
    unique case (mode)
      DUPIN_SPLIT_STROBE: begin
        for (int c = 0; c < `DUPIN_NUM_CHAN; c++) begin
          nxt_irq[c] = core[c].irq;
          nxt_oe_n[c] = ~core[c].out2;
        end
      end
      DUPIN_SINGLE_STROBE: begin
        // Open drain: only ever pulls low
        nxt_irq[`DUPIN_CHAN_A] = 1'b0;
        nxt_oe_n[`DUPIN_CHAN_A] = ~any_irq;
        nxt_irq[`DUPIN_CHAN_B] = 1'b0;
        nxt_oe_n[`DUPIN_CHAN_B] = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_ff <= {`DUPIN_NUM_CHAN{`DUPIN_RST_IRQ}};
      oe_n_ff <= {`DUPIN_NUM_CHAN{`DUPIN_RST_OE_N}};
      aux_n_ff <= {`DUPIN_NUM_CHAN{`DUPIN_RST_AUX_N}};
      txr_n_ff <= {`DUPIN_NUM_CHAN{`DUPIN_RST_RDY_N}};
      rxr_n_ff <= {`DUPIN_NUM_CHAN{`DUPIN_RST_RDY_N}};
      sout_ff <= {`DUPIN_NUM_CHAN{`DUPIN_RST_LINE}};
      rts_n_ff <= {`DUPIN_NUM_CHAN{`DUPIN_RST_MODEM_N}};
      dtr_n_ff <= {`DUPIN_NUM_CHAN{`DUPIN_RST_MODEM_N}};
    end else begin
      irq_ff <= nxt_irq;
      oe_n_ff <= nxt_oe_n;
      aux_n_ff <= nxt_aux_n;
      txr_n_ff <= nxt_txr_n;
      rxr_n_ff <= nxt_rxr_n;
      sout_ff <= nxt_sout;
      rts_n_ff <= nxt_rts_n;
      dtr_n_ff <= nxt_dtr_n;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DUPIN_NUM_CHAN; g++) begin : g_sync
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_ff[g] <= {4{`DUPIN_RST_MODEM_N}};
          sync_ff[g] <= {4{`DUPIN_RST_MODEM_N}};
          ser_meta_ff[g] <= `DUPIN_RST_LINE;
          ser_sync_ff[g] <= `DUPIN_RST_LINE;
        end else begin
          meta_ff[g] <= modem_raw[g];
          sync_ff[g] <= meta_ff[g];
          // Idle-high receive line, reset value matches
          ser_meta_ff[g] <= ser_raw[g];
          ser_sync_ff[g] <= ser_meta_ff[g];
        end
      end
      assign clear_send_n_o[g] = sync_ff[g].clear_send_n;
    end
  endgenerate

  // Status only, no path into the datapath
  assign modem_a_sync_o = sync_ff[`DUPIN_CHAN_A];
  assign modem_b_sync_o = sync_ff[`DUPIN_CHAN_B];
  assign serial_in_o = ser_sync_ff;

  assign chan_a_irq_out_o = irq_ff[`DUPIN_CHAN_A];
  assign chan_b_irq_out_o = irq_ff[`DUPIN_CHAN_B];
  assign chan_a_irq_out_oe_n_o = oe_n_ff[`DUPIN_CHAN_A];
  assign chan_b_irq_out_oe_n_o = oe_n_ff[`DUPIN_CHAN_B];
  assign chan_a_aux_out_n_o = aux_n_ff[`DUPIN_CHAN_A];
  assign chan_b_aux_out_n_o = aux_n_ff[`DUPIN_CHAN_B];
  assign chan_a_tx_ready_n_o = txr_n_ff[`DUPIN_CHAN_A];
  assign chan_b_tx_ready_n_o = txr_n_ff[`DUPIN_CHAN_B];
  assign chan_a_rx_ready_n_o = rxr_n_ff[`DUPIN_CHAN_A];
  assign chan_b_rx_ready_n_o = rxr_n_ff[`DUPIN_CHAN_B];
  assign chan_a_serial_out_o = sout_ff[`DUPIN_CHAN_A];
  assign chan_b_serial_out_o = sout_ff[`DUPIN_CHAN_B];
  assign chan_a_req_send_n_o = rts_n_ff[`DUPIN_CHAN_A];
  assign chan_b_req_send_n_o = rts_n_ff[`DUPIN_CHAN_B];
  assign chan_a_term_ready_n_o = dtr_n_ff[`DUPIN_CHAN_A];
  assign chan_b_term_ready_n_o = dtr_n_ff[`DUPIN_CHAN_B];

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Raw pin, then meta stage, then sync stage
  sequence s_two_stage(raw, synced);
    ##2 synced == $past(raw, 2);
  endsequence

  a_split_irq_b: assert property (bus_mode_i
    |=> chan_b_irq_out_o == $past(core_b_i.irq))
    else $error("B interrupt does not follow core in split mode");
  a_out2_b_drive: assert property (bus_mode_i && core_b_i.out2
    |=> !chan_b_irq_out_oe_n_o && !chan_b_aux_out_n_o)
    else $error("B interrupt not driven with out2 set");
  a_out2_b_float: assert property (bus_mode_i && !core_b_i.out2
    |=> chan_b_irq_out_oe_n_o && chan_b_aux_out_n_o)
    else $error("B interrupt not floated with out2 clear");
  a_single_b_low: assert property (!bus_mode_i
    |=> !chan_b_irq_out_o && !chan_b_irq_out_oe_n_o)
    else $error("B interrupt pin not held low in single mode");
  a_out2_a_gate: assert property (bus_mode_i
    |=> chan_a_irq_out_oe_n_o == chan_a_aux_out_n_o)
    else $error("A interrupt gate and aux pin disagree");
  a_out2_a_drive: assert property (bus_mode_i && core_a_i.out2
    |=> !chan_a_irq_out_oe_n_o && chan_a_irq_out_o == $past(core_a_i.irq))
    else $error("A interrupt not driven with out2 set");
  a_combined_irq: assert property (!bus_mode_i && (core_a_i.irq || core_b_i.irq)
    |=> !chan_a_irq_out_oe_n_o && !chan_a_irq_out_o)
    else $error("Combined interrupt not pulled low");
  a_combined_rel: assert property (!bus_mode_i && !core_a_i.irq && !core_b_i.irq
    |=> chan_a_irq_out_oe_n_o)
    else $error("Combined interrupt held low without a source");
  a_tx_ready_lvl: assert property (core_a_i.tx_can_accept |=> !chan_a_tx_ready_n_o)
    else $error("Tx ready A not asserted");
  a_tx_ready_b: assert property (core_b_i.tx_can_accept |=> !chan_b_tx_ready_n_o)
    else $error("Tx ready B not asserted");
  a_rx_ready_lvl: assert property (!core_b_i.rx_has_data |=> chan_b_rx_ready_n_o)
    else $error("Rx ready B asserted without data");
  a_rx_ready_a: assert property (core_a_i.rx_has_data |=> !chan_a_rx_ready_n_o)
    else $error("Rx ready A not asserted with data waiting");

  // Sampled reset guards the release edge, where the flops still hold reset levels
  a_serial_out_b: assert property (!rst_i
    |=> chan_b_serial_out_o == $past(core_b_i.serial_out))
    else $error("Serial out B does not follow the transmitter");
  a_cts_two_flop: assert property (!rst_i
    |-> s_two_stage(modem_a_i.clear_send_n, clear_send_n_o[0]))
    else $error("Clear-to-send latency not two cycles");
  a_ring_b_sync: assert property (!rst_i
    |-> s_two_stage(modem_b_i.ring_n, modem_b_sync_o.ring_n))
    else $error("Ring status B not passed through two stages");
  a_rx_line_sync: assert property (!rst_i
    |-> s_two_stage(chan_b_serial_in_i, serial_in_o[1]))
    else $error("Receive line B not passed through two stages");
endmodule
`default_nettype wire

/* File: rtl/duart_pin_cfg.svh */
// Constants for the dual UART pin stage: reset levels and line widths.
// Included by the package and the pin module; definitions only.
`ifndef DUART_PIN_CFG_SVH
`define DUART_PIN_CFG_SVH
`define DUPIN_NUM_CHAN 2
`define DUPIN_CHAN_A 0
`define DUPIN_CHAN_B 1
`define DUPIN_MCR_OUT2_BIT 3
`define DUPIN_RST_LINE 1'b1
`define DUPIN_RST_IRQ 1'b0
`define DUPIN_RST_AUX_N 1'b1
`define DUPIN_RST_OE_N 1'b1
`define DUPIN_RST_RDY_N 1'b1
`define DUPIN_RST_MODEM_N 1'b1
`endif

/* File: rtl/dupin_pkg.sv */
// Types shared by the dual UART pin stage.
// Assumes the cfg header is on the include path.
`default_nettype none
`include "duart_pin_cfg.svh"
package dupin_pkg;
  // Core-side status of one channel, as produced by the UART core
  typedef struct packed {
    logic irq;
    logic out2;
    logic tx_can_accept;
    logic rx_has_data;
    logic serial_out;
    logic req_send;
    logic term_ready;
  } dupin_core_s;

  // Active-low modem status pins of one channel
  typedef struct packed {
    logic clear_send_n;
    logic set_ready_n;
    logic carrier_n;
    logic ring_n;
  } dupin_modem_in_s;

  // Bus modes selected by the mode pin
  typedef enum logic {
    DUPIN_SINGLE_STROBE = 1'b0,
    DUPIN_SPLIT_STROBE = 1'b1
  } dupin_mode_e;
endpackage
`default_nettype wire

/* File: verification/dupin_remote_model.sv */
// Remote serial device: sends framed bytes and drives the modem status pins.
// Assumes the bench drives its controls at the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dupin_remote_model
  import dupin_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic send_i,
  input wire logic [7:0] data_i,
  input wire dupin_modem_in_s modem_a_set_i,
  input wire dupin_modem_in_s modem_b_set_i,
  output logic serial_a_o,
  output logic serial_b_o,
  output dupin_modem_in_s modem_a_o,
  output dupin_modem_in_s modem_b_o
);
  logic [9:0] shift_a = 10'h3ff;
  logic [9:0] shift_b = 10'h3ff;
  // Idle high: ones shift in behind each frame
  always @(posedge ref_clk_i) begin
    shift_a <= send_i ? {1'b1, data_i, 1'b0} : {1'b1, shift_a[9:1]};
    shift_b <= send_i ? {1'b1, ~data_i, 1'b0} : {1'b1, shift_b[9:1]};
  end
  assign serial_a_o = shift_a[0];
  assign serial_b_o = shift_b[0];
  assign modem_a_o = modem_a_set_i;
  assign modem_b_o = modem_b_set_i;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Bench for the dual UART pin stage: levels in, pins and synchronisers out.
// Assumes the remote model drives the line side.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dupin_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_mode_i = 1'b1;
  logic send = 1'b0;
  logic [7:0] data = 8'h00;
  dupin_core_s core_a = '0;
  dupin_core_s core_b = '0;
  dupin_modem_in_s mset_a = 4'hf;
  dupin_modem_in_s mset_b = 4'h0;
  dupin_modem_in_s m_a, m_b, ms_a, ms_b;
  logic ser_a, ser_b, irq_a, oe_a, irq_b, oe_b, aux_a, aux_b, tx_a, tx_b, rx_a, rx_b;
  logic so_a, so_b, rts_a, rts_b, dtr_a, dtr_b;
  logic [1:0] cts, sin;
  int error_cnt = 0;
  int check_count = 0;
  dupin_remote_model i_dupin_remote_model (.ref_clk_i(ref_clk_i), .send_i(send), .data_i(data),
    .modem_a_set_i(mset_a), .modem_b_set_i(mset_b), .serial_a_o(ser_a), .serial_b_o(ser_b),
    .modem_a_o(m_a), .modem_b_o(m_b));
  dupin_pins i_dupin_pins (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_mode_i(bus_mode_i),
    .core_a_i(core_a), .core_b_i(core_b), .modem_a_i(m_a), .modem_b_i(m_b),
    .chan_a_serial_in_i(ser_a), .chan_b_serial_in_i(ser_b), .chan_a_irq_out_o(irq_a),
    .chan_a_irq_out_oe_n_o(oe_a), .chan_b_irq_out_o(irq_b), .chan_b_irq_out_oe_n_o(oe_b),
    .chan_a_aux_out_n_o(aux_a), .chan_b_aux_out_n_o(aux_b), .chan_a_tx_ready_n_o(tx_a),
    .chan_b_tx_ready_n_o(tx_b), .chan_a_rx_ready_n_o(rx_a), .chan_b_rx_ready_n_o(rx_b),
    .chan_a_serial_out_o(so_a), .chan_b_serial_out_o(so_b), .chan_a_req_send_n_o(rts_a),
    .chan_b_req_send_n_o(rts_b), .chan_a_term_ready_n_o(dtr_a), .chan_b_term_ready_n_o(dtr_b),
    .clear_send_n_o(cts), .modem_a_sync_o(ms_a), .modem_b_sync_o(ms_b), .serial_in_o(sin));
  always #4 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task automatic set_irq(input logic m, input logic [3:0] i);
    @(posedge ref_clk_i);
    bus_mode_i <= m;
    core_a.irq <= i[0];
    core_a.out2 <= i[1];
    core_b.irq <= i[2];
    core_b.out2 <= i[3];
    step(1);
  endtask
  // Reset levels are judged while reset is still held, then reset is let go
  task automatic t_reset();
    step(2);
    chk({oe_a, oe_b, aux_a, aux_b, tx_a, rx_a, so_a, rts_a}, 8'hff);
    chk({irq_a, irq_b, dtr_b}, 3'h1);
    chk({cts, sin}, 4'hf);
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    $display("reset levels done");
  endtask
  // Pin value only judged while the pin is driven
  task automatic t_split_irq();
    for (int i = 0; i < 16; i++) begin
      set_irq(1'b1, 4'(i));
      chk(i[1] ? irq_a : i[0], i[0]);
      chk({oe_a, aux_a}, {~i[1], ~i[1]});
      chk(i[3] ? irq_b : i[2], i[2]);
      chk({oe_b, aux_b}, {~i[3], ~i[3]});
    end
    $display("split strobe interrupts done");
  endtask
  task automatic t_single_irq();
    for (int i = 0; i < 16; i++) begin
      set_irq(1'b0, 4'(i));
      chk(oe_a ? 1'b0 : irq_a, 1'b0);
      // Braces keep the inversion one bit wide against the 8-bit argument
      chk(oe_a, {~(i[0] | i[2])});
      chk({irq_b, oe_b}, 2'h0);
      chk({aux_a, aux_b}, {~i[1], ~i[3]});
    end
    $display("single strobe interrupts done");
  endtask
  task automatic t_levels();
    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk_i);
      core_a[4:0] <= i[4:0];
      core_b[4:0] <= ~i[4:0];
      step(1);
      chk({tx_a, rx_a, so_a}, {~i[4:3], i[2]});
      chk({rts_a, dtr_a}, {~i[1:0]});
      chk({tx_b, rx_b, so_b}, {i[4:3], ~i[2]});
      chk({rts_b, dtr_b}, {i[1:0]});
    end
    $display("core levels done");
  endtask
  // Levels left by the previous test must not move while modem pins toggle
  task automatic t_modem();
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk_i);
      mset_a <= i[3:0];
      mset_b <= ~i[3:0];
      step(1);
      chk({ms_a, ms_b}, {4'(i - 1), ~4'(i - 1)});
      step(1);
      chk({ms_a, ms_b}, {i[3:0], ~i[3:0]});
      chk(cts, {~i[3], i[3]});
      chk({tx_a, rx_a, so_a, tx_b, rx_b, so_b}, 6'h0e);
    end
    $display("modem inputs done");
  endtask
  task automatic t_serial(input logic [7:0] d);
    @(posedge ref_clk_i);
    send <= 1'b1;
    data <= d;
    @(posedge ref_clk_i);
    send <= 1'b0;
    step(2);
    chk(sin, 2'h0);
    for (int b = 0; b < 8; b++) begin
      step(1);
      chk(sin, {~d[b], d[b]});
    end
    step(3);
    chk(sin, 2'h3);
    $display("serial frame done");
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_split_irq();
    t_single_irq();
    t_levels();
    t_modem();
    t_serial(8'ha5);
    t_serial(8'h3c);
    summarize();
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
